// file: design/fault_status_registers.sv
// fault and status register bank: main status word with summary bits, interface error and tx queue status words
`timescale 1ns/10ps
module fault_status_registers #(
  parameter int tx_depth = 512
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access from the host port decoder
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // event pulses from the rest of the device
  input wire logic osc_out_of_range,
  input wire logic host_select_lost,
  input wire logic host_timeout,
  input wire logic host_timeout_enable,
  input wire logic chain_queue_overflow_evt,
  input wire logic chain_check_bit_evt,
  input wire logic chain_checksum_evt,
  input wire logic chain_stuck_evt,
  input wire logic tx_overflow_evt,
  input wire logic tx_underflow_evt,
  input wire logic tx_single_error_evt,
  input wire logic [$clog2(tx_depth+1)-1:0] tx_word_count,
  // fault reporting masks, one per interface and tx error bit
  input wire logic [15:0] interface_error_mask,
  input wire logic [15:0] tx_error_mask,
  // open-drain alarm pin and forwarding gate
  output logic alarm_out,
  output logic alarm_oe,
  input wire logic alarm_in,
  output logic forward_enable
);
  localparam int cw = $clog2(tx_depth+1);
  localparam int lw = fault_status_pkg::tx_level_width;
  localparam int rw = fault_status_pkg::reg_width;

  // a new event wins over a clear that lands in the same cycle, so an
  // error raised while software clears is never lost
  function automatic logic [rw-1:0] sticky(
    input logic [rw-1:0] flags,
    input logic clear,
    input logic [rw-1:0] events
  );
    return (clear ? '0 : flags) | events;
  endfunction : sticky

  function automatic logic addr_is(
    input logic [3:0] addr,
    input logic [3:0] index
  );
    return addr == index;
  endfunction : addr_is

  // register selects from the host port decoder
  wire sel_main = addr_is(reg_addr, fault_status_pkg::main_status_addr);
  wire sel_if = addr_is(reg_addr,
    fault_status_pkg::interface_error_status_addr);
  wire sel_tx = addr_is(reg_addr,
    fault_status_pkg::tx_queue_status_addr);
  wire mapped = sel_main || sel_if || sel_tx;

  // only bit 15 of a main status write acts; the error words ignore writes
  wire clear_write = reg_wr && sel_main &&
    reg_wdata[fault_status_pkg::clear_all_flags_bit];

  // latched flags, each kept at its own bit position of its word
  logic [rw-1:0] interface_error_status;
  logic [rw-1:0] tx_flags;
  logic [rw-1:0] main_flags;
  logic [lw-1:0] tx_level;

  // event vectors
  logic [rw-1:0] if_events;
  logic [rw-1:0] tx_events;
  logic [rw-1:0] main_events;

  always_comb begin
    if_events = '0;
    if_events[fault_status_pkg::host_select_error_bit] =
      host_select_lost;
    if_events[fault_status_pkg::host_timeout_error_bit] =
      host_timeout && host_timeout_enable;
    if_events[fault_status_pkg::chain_command_queue_overflow_bit] =
      chain_queue_overflow_evt;
    if_events[fault_status_pkg::chain_check_bit_error_bit] =
      chain_check_bit_evt;
    if_events[fault_status_pkg::chain_checksum_error_bit] =
      chain_checksum_evt;
    if_events[fault_status_pkg::chain_input_stuck_error_bit] =
      chain_stuck_evt;
  end

  always_comb begin
    tx_events = '0;
    tx_events[fault_status_pkg::tx_queue_overflow_bit] =
      tx_overflow_evt;
    tx_events[fault_status_pkg::tx_queue_underflow_bit] =
      tx_underflow_evt;
    tx_events[fault_status_pkg::tx_queue_single_error_bit] =
      tx_single_error_evt;
  end

  always_comb begin
    main_events = '0;
    main_events[fault_status_pkg::oscillator_range_error_bit] =
      osc_out_of_range;
  end

  // power-on flag has no event: only a clear takes it down
  wire [rw-1:0] next_interface_error_status =
    sticky(interface_error_status, clear_write, if_events);
  wire [rw-1:0] next_tx_flags = sticky(tx_flags, clear_write, tx_events);
  wire [rw-1:0] next_main_flags =
    sticky(main_flags, clear_write, main_events);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interface_error_status <= fault_status_pkg::interface_error_reset;
    end else begin
      interface_error_status <= next_interface_error_status;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_flags <= fault_status_pkg::tx_queue_status_reset;
    end else begin
      tx_flags <= next_tx_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_flags <= fault_status_pkg::main_flags_reset;
    end else begin
      main_flags <= next_main_flags;
    end
  end

  // the level follows the count one cycle late; a full queue and one
  // word short of full both show the saturated value
  wire level_saturated =
    tx_word_count >= cw'(fault_status_pkg::tx_level_saturated);
  wire [lw-1:0] next_tx_level = level_saturated ?
    fault_status_pkg::tx_level_saturated : tx_word_count[lw-1:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_level <= '0;
    end else begin
      tx_level <= next_tx_level;
    end
  end

  // summaries point software at the word that holds the detail
  wire chain_summary = |(interface_error_status &
    fault_status_pkg::chain_error_field_mask);
  wire tx_summary = |tx_flags;

  // masks only gate the pin; the flags themselves still latch
  wire if_unmasked = |(interface_error_status & ~interface_error_mask);
  wire tx_unmasked = |(tx_flags & ~tx_error_mask);
  // oscillator and power-on flags have no mask bit
  wire any_fault = if_unmasked || tx_unmasked || (|main_flags);

  // open-drain pin: only ever pulled low, released otherwise
  assign alarm_out = 1'b0;
  assign alarm_oe = any_fault;
  // forwarding held off until the host has cleared the power-on flag
  assign forward_enable =
    !main_flags[fault_status_pkg::power_on_reset_bit];

  logic [rw-1:0] main_word;
  logic [rw-1:0] tx_word;
  always_comb begin
    main_word = main_flags;
    main_word[fault_status_pkg::chain_error_summary_bit] =
      chain_summary;
    main_word[fault_status_pkg::tx_queue_error_summary_bit] =
      tx_summary;
    // the global bit reads the pin back, so it shows an outside pull too
    main_word[fault_status_pkg::global_error_bit] = !alarm_in;
  end

  always_comb begin
    tx_word = tx_flags;
    tx_word[lw-1:0] = tx_level;
  end

  wire [rw-1:0] read_word = sel_main ? main_word :
    sel_if ? interface_error_status :
    sel_tx ? tx_word : '0;

  // read data is registered and holds until the next read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= read_word;
    end
  end
  assign reg_hit = (reg_rd || reg_wr) && mapped;
endmodule : fault_status_registers

// file: common/fault_status_pkg.sv
// constants for the fault and status register bank
package fault_status_pkg;
  // register offsets (register index on the host port)
  localparam logic [3:0] main_status_addr = 4'h7;
  localparam logic [3:0] interface_error_status_addr = 4'h8;
  localparam logic [3:0] tx_queue_status_addr = 4'h9;
  localparam int reg_width = 16;
  // main status word bit positions
  localparam int clear_all_flags_bit = 15;
  localparam int chain_error_summary_bit = 14;
  localparam int tx_queue_error_summary_bit = 12;
  localparam int oscillator_range_error_bit = 2;
  localparam int power_on_reset_bit = 1;
  localparam int global_error_bit = 0;
  // interface error word bit positions
  localparam int host_select_error_bit = 9;
  localparam int host_timeout_error_bit = 8;
  localparam int chain_command_queue_overflow_bit = 4;
  localparam int chain_check_bit_error_bit = 3;
  localparam int chain_checksum_error_bit = 1;
  localparam int chain_input_stuck_error_bit = 0;
  // chain errors that feed the chain summary bit
  localparam logic [15:0] chain_error_field_mask = 16'h001b;
  // transmit queue status word
  localparam int tx_queue_overflow_bit = 15;
  localparam int tx_queue_underflow_bit = 14;
  localparam int tx_queue_single_error_bit = 13;
  localparam int tx_level_width = 9;
  localparam logic [8:0] tx_level_saturated = 9'h1ff;
  // reset values
  localparam logic [15:0] interface_error_reset = 16'h0000;
  localparam logic [15:0] tx_queue_status_reset = 16'h0000;
  // main status flags held in this bank: only the power-on flag starts set
  localparam logic [15:0] main_flags_reset = 16'h0002;
endpackage : fault_status_pkg

// file: tb/alarm_pullup.sv
// alarm line with its external pull-up, as the host side sees it
`timescale 1ns/10ps
module alarm_pullup (
  input wire logic alarm_out,
  input wire logic alarm_oe,
  output logic alarm_in
);
  // released line floats up to the pull-up level
  assign alarm_in = alarm_oe ? alarm_out : 1'b1;
endmodule : alarm_pullup

// file: tb/fault_status_sva.sv
// assertions on the fault and status register bank ports
`timescale 1ns/10ps
module fault_status_sva (
  input wire logic clk, rst_n, reg_rd, reg_wr, reg_hit, alarm_in,
  input wire logic alarm_out, alarm_oe, forward_enable, host_select_lost,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata, interface_error_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rd_s(a); reg_rd && reg_addr == a; endsequence
  sequence clr_s; reg_wr && reg_addr == 4'h7 && reg_wdata[15]; endsequence
  AST_GLOBAL: assert property (rd_s(4'h7) |=>
    reg_rdata[0] == !$past(alarm_in)) else $error("global bit wrong");
  AST_POR_FWD: assert property (rd_s(4'h7) |=>
    reg_rdata[1] == !$past(forward_enable)) else $error("por bit wrong");
  AST_CLEAR: assert property (clr_s |=> forward_enable)
    else $error("clear did not drop power-on flag");
  AST_CS: assert property (host_select_lost &&
    !interface_error_mask[9] |=> alarm_oe) else $error("cs error no alarm");
  AST_INTERFACE_ERROR_STATUS_RES: assert property (rd_s(4'h8) |=> reg_rdata[15:10] == 6'h00 &&
    reg_rdata[7:5] == 3'h0 && !reg_rdata[2])
    else $error("reserved bits set");
  AST_UNMAP: assert property (rd_s(4'h3) |->
    !reg_hit ##1 reg_rdata == 16'h0000) else $error("unmapped read");
  AST_HIT: assert property (rd_s(4'h8) |-> reg_hit)
    else $error("mapped read without hit");
  AST_ALARM_POR: assert property (!forward_enable |-> alarm_oe)
    else $error("power-on flag without alarm");
  AST_OD_LOW: assert property (alarm_out == 1'b0)
    else $error("alarm drives high");
endmodule : fault_status_sva
bind fault_status_registers fault_status_sva chk (.*);

// file: tb/test_fault_status_registers.sv
// self-checking bench for the fault and status register bank
`timescale 1ns/10ps
module test_fault_status_registers;
  logic clk = 0, rst_n = 0, reg_rd = 0, reg_wr = 0, host_timeout_enable = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, interface_error_mask = 0, tx_error_mask = 0;
  logic [9:0] tx_word_count = 0, ev = 0;
  wire logic [15:0] reg_rdata;
  wire logic reg_hit, alarm_out, alarm_oe, alarm_in, forward_enable;
  int mismatches = 0, n_checks = 0, cyc = 0;
  logic [15:0] ev_bit [10] = '{16'h0005, 16'h0200, 16'h0100, 16'h0010,
    16'h0008, 16'h0002, 16'h0001, 16'h8000, 16'h4000, 16'h2000};
  int lvl [5] = '{0, 3, 510, 511, 512};
  fault_status_registers uut (.*, .osc_out_of_range(ev[0]),
    .host_select_lost(ev[1]), .host_timeout(ev[2]),
    .chain_queue_overflow_evt(ev[3]), .chain_check_bit_evt(ev[4]),
    .chain_checksum_evt(ev[5]), .chain_stuck_evt(ev[6]),
    .tx_overflow_evt(ev[7]), .tx_underflow_evt(ev[8]),
    .tx_single_error_evt(ev[9]));
  alarm_pullup pin (.alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .alarm_in(alarm_in));
  always #25 clk = ~clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask : rd
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  task pulse(input int i);
    @(posedge clk);
    ev <= 10'h1 << i;
    @(posedge clk);
    ev <= 0;
  endtask : pulse
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task t_reset;
    rd(4'h8, 16'h0000);
    rd(4'h9, 16'h0000);
    rd(4'h7, 16'h0003);
    rd(4'h3, 16'h0000);
    wr(4'h8, 16'hffff);
    wr(4'h7, 16'h7fff);
    rd(4'h8, 16'h0000);
    rd(4'h7, 16'h0003);
    wr(4'h7, 16'h8000);
    rd(4'h7, 16'h0000);
    chk({15'h0, forward_enable}, 16'h0001);
    $display("reset and clear test done");
  endtask : t_reset
  task t_events;
    pulse(2);
    rd(4'h8, 16'h0000);
    @(posedge clk);
    host_timeout_enable <= 1;
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      rd(i == 0 ? 4'h7 : i < 7 ? 4'h8 : 4'h9, ev_bit[i]);
      rd(4'h7, i == 0 ? 16'h0005 : i < 3 ? 16'h0001 :
        i < 7 ? 16'h4001 : 16'h1001);
      wr(4'h7, 16'h8000);
      rd(i == 0 ? 4'h7 : i < 7 ? 4'h8 : 4'h9, 16'h0000);
    end
    $display("event test done");
  endtask : t_events
  task t_masks;
    @(posedge clk);
    interface_error_mask <= 16'h0200;
    tx_error_mask <= 16'h8000;
    pulse(1);
    rd(4'h8, 16'h0200);
    rd(4'h7, 16'h0000);
    chk({15'h0, alarm_oe}, 16'h0000);
    pulse(7);
    rd(4'h7, 16'h1000);
    pulse(6);
    rd(4'h7, 16'h5001);
    chk({14'h0, alarm_out, alarm_oe}, 16'h0001);
    // clear and a new chain event in the same cycle: the event survives
    @(posedge clk);
    reg_addr <= 4'h7;
    reg_wdata <= 16'h8000;
    reg_wr <= 1;
    ev <= 10'h010;
    @(negedge clk);
    chk({15'h0, reg_hit}, 16'h0001);
    @(posedge clk);
    reg_wr <= 0;
    ev <= 0;
    rd(4'h8, 16'h0008);
    rd(4'h9, 16'h0000);
    @(posedge clk);
    interface_error_mask <= 16'h0000;
    tx_error_mask <= 16'h0000;
    wr(4'h7, 16'h8000);
    rd(4'h8, 16'h0000);
    $display("mask and set-wins test done");
  endtask : t_masks
  task t_level;
    foreach (lvl[k]) begin
      @(posedge clk);
      tx_word_count <= lvl[k][9:0];
      rd(4'h9, lvl[k] >= 511 ? 16'h01ff : lvl[k][15:0]);
    end
    $display("level test done");
  endtask : t_level
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_events();
    t_masks();
    t_level();
    test_done();
  end
endmodule : test_fault_status_registers
